// ==== rtl/fpcsu_regs.vh ====
// Constants for the fp compare and status unit: bit positions, masks, opcodes.
// Status bits are numbered 0 (most significant) to 31, held as vectors [0:31].
`ifndef FPCSU_REGS_VH
`define FPCSU_REGS_VH

// Status register bit positions
`define FPCSU_BIT_EXC_SUM      0
`define FPCSU_BIT_EN_EXC_SUM   1
`define FPCSU_BIT_INV_SUM      2
`define FPCSU_BIT_OVERFLOW     3
`define FPCSU_BIT_UNDERFLOW    4
`define FPCSU_BIT_ZERODIV      5
`define FPCSU_BIT_INEXACT      6
`define FPCSU_BIT_SNAN_INV     7
`define FPCSU_BIT_CMP_INV      12
`define FPCSU_BIT_COND_CODE    16
`define FPCSU_BIT_INV_EN       24
`define FPCSU_BIT_OVF_EN       25
`define FPCSU_BIT_UNF_EN       26
`define FPCSU_BIT_ZDV_EN       27
`define FPCSU_BIT_INX_EN       28
`define FPCSU_FIELD_W          4
`define FPCSU_FIELDS           8
`define FPCSU_SRC_LOW          32

// Status register reset value
`define FPCSU_STAT_RST         32'h0000_0000
// Exception bits whose rise sets the exception summary
`define FPCSU_EXC_RISE_MASK    32'h1FF8_0700
// Exception bits cleared when copied to a condition field
`define FPCSU_EXC_CLR_MASK     32'h9FF8_0700
// Invalid-operation detail bits feeding the invalid summary
`define FPCSU_INV_MASK         32'h01F8_0700
// Field 0 select in status orientation
`define FPCSU_FIELD0_MASK      32'hF000_0000

// Opcodes
`define FPCSU_OP_CMPU          3'h0
`define FPCSU_OP_CMPO          3'h1
`define FPCSU_OP_MFS           3'h2
`define FPCSU_OP_MCRFS         3'h3
`define FPCSU_OP_MTFSFI        3'h4
`define FPCSU_OP_MTFSF         3'h5

`endif

// ==== rtl/fpcsu_cmp.v ====
// Double-precision comparator: one-hot less/greater/equal/unordered and NaN kinds.
// Assumes operands held stable by the caller; purely combinational.
`timescale 1ns/1ns
module fpcsu_cmp #(
   parameter EXP_W  = 11,
   parameter FRAC_W = 52
) (
   input  wire [EXP_W+FRAC_W:0] opa,
   input  wire [EXP_W+FRAC_W:0] opb,
   output reg                   lt,
   output reg                   gt,
   output reg                   eq,
   output reg                   un,
   output reg                   snan,
   output reg                   qnan
);
   localparam W = EXP_W + FRAC_W + 1;

   wire               sa    = opa[W-1];
   wire               sb    = opb[W-1];
   wire [W-2:0]       maga  = opa[W-2:0];
   wire [W-2:0]       magb  = opb[W-2:0];
   wire               nan_a = (&opa[W-2:FRAC_W]) && (|opa[FRAC_W-1:0]);
   wire               nan_b = (&opb[W-2:FRAC_W]) && (|opb[FRAC_W-1:0]);
   wire               sn_a  = nan_a && !opa[FRAC_W-1];
   wire               sn_b  = nan_b && !opb[FRAC_W-1];

   always @* begin
      lt   = 1'b0;
      gt   = 1'b0;
      eq   = 1'b0;
      un   = 1'b0;
      snan = sn_a || sn_b;
      qnan = (nan_a && !sn_a) || (nan_b && !sn_b);
      if (nan_a || nan_b) begin
         un = 1'b1;
      // (RL1) signed zeros equal
      end else if ((maga == magb && sa == sb) || (maga == 0 && magb == 0)) begin
         eq = 1'b1;
      end else if (sa != sb) begin
         lt = sa;
         gt = sb;
      end else if (sa == 1'b0) begin
         lt = maga < magb;
         gt = maga > magb;
      end else begin
         lt = maga > magb;
         gt = maga < magb;
      end
   end
endmodule

// ==== rtl/fpcsu_top.v ====
// Floating-point compare and status/control register move unit.
// Assumes one instruction per op_valid while op_ready is high, and that the
// sequencer reports outstanding fp work on fp_busy and exc_pending.
//
// Overview of operation
// (RL1) Positive and negative zero compare equal
// (RL2) Compare writes one-hot field and condition code
// (RL3) Code bits: less, greater, equal, unordered
// (RL4) Any NaN operand reports unordered
// (RL5) Unordered compare: signaling NaN sets flag
// (RL6) Ordered signaling NaN: both flags, enable-gated
// (RL7) Ordered quiet NaN sets compare invalid
// (RL8) Software ignores field one after compare
// (RL9) Status ops wait for earlier fp work
// (RL10) Earlier exceptions recorded before status op
// (RL11) Hold later status users until done
// (RL12) Fp loads and stores never held
// (RL13) Move-from copies status to low word
// (RL14) Status-to-condition copy clears copied exceptions
// (RL15) Immediate write changes only chosen field
// (RL16) Field 0 immediate: summary, overflow direct
// (RL17) Enabled and invalid summaries always derived
// (RL18) Masked write loads selected fields from source
// (RL19) Dot immediate form also updates condition register
// (RL20) Exception rise sets exception summary
// (RL21) Masked field 0: summary, overflow from source
// (RL22) Mask bit 0 selects status field 0
`timescale 1ns/1ns
`include "fpcsu_regs.vh"
module fpcsu_top #(
   parameter DATA_W = 64
) (
   input  wire              clk,
   input  wire              reset_n,
   input  wire              ce,
   input  wire              op_valid,
   input  wire [2:0]        op_code,
   input  wire              op_dot,
   input  wire [2:0]        dest_cond_field,
   input  wire [2:0]        src_status_field,
   input  wire [0:3]        immediate_nibble,
   input  wire [0:7]        field_mask,
   input  wire [DATA_W-1:0] fp_src_a,
   input  wire [0:63]       fp_src_b,
   input  wire              fp_busy,
   input  wire              exc_pending,
   input  wire [0:31]       exc_set,
   output reg               op_ready_q,
   output reg               done_q,
   output reg               fp_hold_q,
   output reg               fp_mem_hold_q,
   output reg  [0:31]       fp_status_control_reg,
   output reg               fp_dest_wr_q,
   output reg  [0:63]       fp_dest_q,
   output reg               cr_wr_q,
   output reg  [2:0]        cr_field_q,
   output reg  [0:3]        cr_data_q,
   output reg               cr1_wr_q,
   output reg  [0:3]        cr1_data_q
);
   localparam ST_IDLE = 2'd0;
   localparam ST_SYNC = 2'd1;
   localparam ST_EXEC = 2'd2;

   reg  [1:0]        state_q;
   reg  [1:0]        state_d;
   reg  [2:0]        opc_q;
   reg               dot_q;
   reg  [2:0]        dest_cond_field_q;
   reg  [2:0]        src_status_field_q;
   reg  [0:3]        imm_q;
   reg  [0:7]        fm_q;
   reg  [DATA_W-1:0] a_q;
   reg  [0:63]       b_q;
   reg  [0:31]       stat_d;
   reg  [0:31]       stat_w;
   reg               auto_sum;
   reg               done_d;
   reg               hold_d;
   reg               fp_wr_d;
   reg  [0:63]       fp_dest_d;
   reg               cr_wr_d;
   reg  [2:0]        cr_field_d;
   reg  [0:3]        cr_data_d;
   reg               cr1_wr_d;
   reg  [0:3]        cr1_data_d;
   reg  [0:3]        cmp_res;
   integer           i;

   // Compare opcodes of either variant
   function is_cmp_op;
      input [2:0] op;
      begin
         is_cmp_op = (op == `FPCSU_OP_CMPU) || (op == `FPCSU_OP_CMPO);
      end
   endfunction

   // First status bit of field idx
   function [4:0] field_base;
      input [2:0] idx;
      begin
         field_base = {idx, 2'b00};
      end
   endfunction

   wire              c_lt;
   wire              c_gt;
   wire              c_eq;
   wire              c_un;
   wire              c_snan;
   wire              c_qnan;
   wire              accept   = op_valid && op_ready_q;
   wire              is_cmp   = is_cmp_op(op_code);
   wire              q_is_cmp = is_cmp_op(opc_q);
   // Earlier fp work finished and its exceptions recorded
   wire              sync_clear = !fp_busy && !exc_pending;

   fpcsu_cmp #(
      .EXP_W  (11),
      .FRAC_W (52)
   ) u_cmp (
      .opa  (a_q),
      .opb  (b_q),
      .lt   (c_lt),
      .gt   (c_gt),
      .eq   (c_eq),
      .un   (c_un),
      .snan (c_snan),
      .qnan (c_qnan)
   );

   // Mask of the four status bits of field idx
   function [0:31] field_sel;
      input [2:0] idx;
      begin
         field_sel = `FPCSU_FIELD0_MASK >> field_base(idx);
      end
   endfunction

   // Any tracked exception bit going from zero to one
   function rises;
      input [0:31] old_v;
      input [0:31] new_v;
      begin
         rises = |((~old_v) & new_v & `FPCSU_EXC_RISE_MASK);
      end
   endfunction

   // Recompute enabled and invalid summaries from their sources
   function [0:31] derive;
      input [0:31] s;
      reg          inv;
      begin
         inv = |(s & `FPCSU_INV_MASK);
         derive = s;
         derive[`FPCSU_BIT_INV_SUM] = inv;
         derive[`FPCSU_BIT_EN_EXC_SUM] =
            (inv && s[`FPCSU_BIT_INV_EN]) ||
            (s[`FPCSU_BIT_OVERFLOW] && s[`FPCSU_BIT_OVF_EN]) ||
            (s[`FPCSU_BIT_UNDERFLOW] && s[`FPCSU_BIT_UNF_EN]) ||
            (s[`FPCSU_BIT_ZERODIV] && s[`FPCSU_BIT_ZDV_EN]) ||
            (s[`FPCSU_BIT_INEXACT] && s[`FPCSU_BIT_INX_EN]);
      end
   endfunction

   always @* begin
      state_d    = state_q;
      stat_w     = fp_status_control_reg;
      auto_sum   = 1'b1;
      done_d     = 1'b0;
      hold_d     = fp_hold_q;
      fp_wr_d    = 1'b0;
      fp_dest_d  = fp_dest_q;
      cr_wr_d    = 1'b0;
      cr_field_d = cr_field_q;
      cr_data_d  = cr_data_q;
      cr1_wr_d   = 1'b0;
      cr1_data_d = cr1_data_q;
      // (RL3) one-hot code order
      cmp_res    = {c_lt, c_gt, c_eq, c_un};
      case (state_q)
         ST_IDLE: begin
            if (accept) begin
               if (is_cmp) begin
                  state_d = ST_EXEC;
               end else begin
                  // (RL11) hold status users
                  hold_d  = 1'b1;
                  state_d = ST_SYNC;
               end
            end
         end
         ST_SYNC: begin
            // (RL9) (RL10) wait earlier work
            if (sync_clear) begin
               state_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_d = ST_IDLE;
            done_d  = 1'b1;
            hold_d  = 1'b0;
            case (opc_q)
               `FPCSU_OP_CMPU,
               `FPCSU_OP_CMPO: begin
                  // (RL2) (RL4) field and code
                  stat_w[`FPCSU_BIT_COND_CODE +: 4] = cmp_res;
                  cr_wr_d    = 1'b1;
                  cr_field_d = dest_cond_field_q;
                  cr_data_d  = cmp_res;
                  // (RL5) (RL6) signaling NaN flag
                  if (c_snan) begin
                     stat_w[`FPCSU_BIT_SNAN_INV] = 1'b1;
                  end
                  if (opc_q == `FPCSU_OP_CMPO) begin
                     // (RL6) enable-gated compare flag
                     if (c_snan) begin
                        if (!fp_status_control_reg[`FPCSU_BIT_INV_EN]) begin
                           stat_w[`FPCSU_BIT_CMP_INV] = 1'b1;
                        end
                     // (RL7) quiet NaN flag
                     end else if (c_qnan) begin
                        stat_w[`FPCSU_BIT_CMP_INV] = 1'b1;
                     end
                  end
               end
               `FPCSU_OP_MFS: begin
                  // (RL13) status to low word
                  fp_wr_d   = 1'b1;
                  fp_dest_d = {32'h0000_0000, fp_status_control_reg};
               end
               `FPCSU_OP_MCRFS: begin
                  // (RL14) copy then clear
                  cr_wr_d    = 1'b1;
                  cr_field_d = dest_cond_field_q;
                  cr_data_d  = fp_status_control_reg[field_base(src_status_field_q) +: 4];
                  stat_w     = fp_status_control_reg &
                               ~(`FPCSU_EXC_CLR_MASK & field_sel(src_status_field_q));
               end
               `FPCSU_OP_MTFSFI: begin
                  // (RL15) one field only
                  stat_w[field_base(dest_cond_field_q) +: 4] = immediate_q_nib(imm_q);
                  if (dest_cond_field_q == 3'd0) begin
                     // (RL16) direct summary load
                     auto_sum = 1'b0;
                  end
               end
               `FPCSU_OP_MTFSF: begin
                  // (RL18) (RL22) masked fields
                  for (i = 0; i < `FPCSU_FIELDS; i = i + 1) begin
                     if (fm_q[i]) begin
                        stat_w[field_base(i[2:0]) +: 4] =
                           b_q[`FPCSU_SRC_LOW + field_base(i[2:0]) +: 4];
                     end
                  end
                  if (fm_q[0]) begin
                     // (RL21) direct summary load
                     auto_sum = 1'b0;
                  end
               end
               default: begin
                  fp_wr_d = 1'b0;
               end
            endcase
         end
         default: begin
            state_d = ST_IDLE;
            hold_d  = 1'b0;
         end
      endcase
      // Recorded exceptions win over any clear in the same cycle
      stat_d = stat_w | exc_set;
      // (RL20) summary on rise
      if (auto_sum && rises(fp_status_control_reg, stat_d)) begin
         stat_d[`FPCSU_BIT_EXC_SUM] = 1'b1;
      end
      // (RL17) derived summaries
      stat_d = derive(stat_d);
      // (RL19) dot form updates field one
      if (state_q == ST_EXEC && dot_q && !q_is_cmp) begin
         cr1_wr_d   = 1'b1;
         cr1_data_d = stat_d[0:3];
      end
   end

   // Identity helper keeps the immediate width explicit
   function [0:3] immediate_q_nib;
      input [0:3] v;
      begin
         immediate_q_nib = v;
      end
   endfunction

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q               <= ST_IDLE;
         opc_q                 <= 3'h0;
         dot_q                 <= 1'b0;
         dest_cond_field_q                <= 3'h0;
         src_status_field_q                <= 3'h0;
         imm_q                 <= 4'h0;
         fm_q                  <= 8'h00;
         a_q                   <= {DATA_W{1'b0}};
         b_q                   <= 64'h0000_0000_0000_0000;
         op_ready_q            <= 1'b1;
         done_q                <= 1'b0;
         fp_hold_q             <= 1'b0;
         fp_mem_hold_q         <= 1'b0;
         fp_status_control_reg <= `FPCSU_STAT_RST;
         fp_dest_wr_q          <= 1'b0;
         fp_dest_q             <= 64'h0000_0000_0000_0000;
         cr_wr_q               <= 1'b0;
         cr_field_q            <= 3'h0;
         cr_data_q             <= 4'h0;
         cr1_wr_q              <= 1'b0;
         cr1_data_q            <= 4'h0;
      end else if (ce) begin
         state_q               <= state_d;
         if (accept) begin
            opc_q  <= op_code;
            dot_q  <= op_dot;
            dest_cond_field_q <= dest_cond_field;
            src_status_field_q <= src_status_field;
            imm_q  <= immediate_nibble;
            fm_q   <= field_mask;
            a_q    <= fp_src_a;
            b_q    <= fp_src_b;
         end
         op_ready_q            <= (state_d == ST_IDLE);
         done_q                <= done_d;
         fp_hold_q             <= hold_d;
         // (RL12) memory ops never held
         fp_mem_hold_q         <= 1'b0;
         fp_status_control_reg <= stat_d;
         fp_dest_wr_q          <= fp_wr_d;
         fp_dest_q             <= fp_dest_d;
         cr_wr_q               <= cr_wr_d;
         cr_field_q            <= cr_field_d;
         cr_data_q             <= cr_data_d;
         cr1_wr_q              <= cr1_wr_d;
         cr1_data_q            <= cr1_data_d;
      end
   end
endmodule

// ==== rtl/unused_placeholder_none.v ====
// Holds no logic: the unit is fpcsu_top.v with its comparator fpcsu_cmp.v.
// Assumes nothing of its surroundings.

// ==== testbench/fpcsu_top_checker.sv ====
// Checker for fpcsu_top: compare results, flags and status-op sequencing.
// Bound to every fpcsu_top; sees only its ports, single clock domain.
`timescale 1ns/1ns
`include "fpcsu_regs.vh"
module fpcsu_top_checker (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        ce,
   input wire logic        op_valid,
   input wire logic [2:0]  op_code,
   input wire logic [63:0] fp_src_a,
   input wire logic [0:63] fp_src_b,
   input wire logic        fp_busy,
   input wire logic        exc_pending,
   input wire logic [0:31] exc_set,
   input wire logic        op_ready_q,
   input wire logic        done_q,
   input wire logic        fp_hold_q,
   input wire logic        fp_mem_hold_q,
   input wire logic [0:31] fp_status_control_reg,
   input wire logic        fp_dest_wr_q,
   input wire logic [0:63] fp_dest_q,
   input wire logic        cr_wr_q,
   input wire logic [0:3]  cr_data_q
);
   wire acc = ce && op_valid && op_ready_q;
   wire cmp = acc && op_code <= `FPCSU_OP_CMPO;
   wire sop = acc && op_code >= `FPCSU_OP_MFS;
   wire na  = &fp_src_a[62:52] && |fp_src_a[51:0];
   wire nb  = &fp_src_b[1:11] && |fp_src_b[12:63];
   wire sn  = (na && !fp_src_a[51]) || (nb && !fp_src_b[12]);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_cmp_one_hot:
      assert property (cmp |-> ##2 done_q && cr_wr_q && $onehot(cr_data_q)
         && fp_status_control_reg[16:19] == cr_data_q) else $error("compare code bad");
   a_nan_unord:
      assert property (cmp && (na || nb) |-> ##2 cr_data_q == 4'b0001)
         else $error("nan not unordered");
   a_snan_flag:
      assert property (cmp && sn |-> ##2 fp_status_control_reg[`FPCSU_BIT_SNAN_INV])
         else $error("snan flag missing");
   a_qnan_ordered:
      assert property (cmp && op_code == `FPCSU_OP_CMPO && (na || nb) && !sn
         |-> ##2 fp_status_control_reg[`FPCSU_BIT_CMP_INV]) else $error("qnan flag missing");
   a_sync_wait:
      assert property (fp_hold_q && (fp_busy || exc_pending) |-> ##2 !done_q)
         else $error("status op ran before sync");
   a_hold_set:
      assert property (sop |=> fp_hold_q && !op_ready_q) else $error("hold not raised");
   a_hold_release:
      assert property ($fell(fp_hold_q) |-> done_q) else $error("hold dropped early");
   a_mem_free:
      assert property (!fp_mem_hold_q) else $error("memory access held");
   a_mfs_copy:
      assert property (fp_dest_wr_q |-> fp_dest_q[32:63] == $past(fp_status_control_reg)
         && fp_dest_q[0:31] == 32'h0000_0000) else $error("move-from data bad");
   a_exc_rise:
      assert property (ce && op_ready_q
         && |(exc_set & ~fp_status_control_reg & `FPCSU_EXC_RISE_MASK)
         |=> fp_status_control_reg[`FPCSU_BIT_EXC_SUM]) else $error("summary not set");
   cover property (cmp && sn);
   cover property (sop && fp_busy);
   cover property (fp_dest_wr_q);
endmodule
bind fpcsu_top fpcsu_top_checker u_chk (.clk, .reset_n, .ce, .op_valid, .op_code, .fp_src_a,
   .fp_src_b, .fp_busy, .exc_pending, .exc_set, .op_ready_q, .done_q, .fp_hold_q,
   .fp_mem_hold_q, .fp_status_control_reg, .fp_dest_wr_q, .fp_dest_q, .cr_wr_q, .cr_data_q);

// ==== testbench/fpcsu_seq_model.sv ====
// Sequencer model: reports outstanding fp work for len cycles after go.
// Assumes go and len are driven just after a rising edge.
`timescale 1ns/1ns
module fpcsu_seq_model (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       go,
   input  wire logic [3:0] len,
   output wire logic       fp_busy,
   output wire logic       exc_pending
);
   logic [3:0] cnt_q;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         cnt_q <= 4'h0;
      else if (go)
         cnt_q <= len;
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
   end
   // Work first, exceptions recorded last
   assign fp_busy     = cnt_q > 4'h2;
   assign exc_pending = cnt_q != 4'h0 && cnt_q <= 4'h2;
endmodule

// ==== testbench/test_fpcsu_top.sv ====
// Self-checking bench for fpcsu_top with a sequencer model on the sync inputs.
// Assumes rtl/ is on the include path.
`timescale 1ns/1ns
`include "fpcsu_regs.vh"
module test_fpcsu_top;
   logic        clk, reset_n, ce, op_valid, op_dot, go, dt, ve, sn;
   logic [2:0]  op_code, dest_cond_field, src_status_field, fld;
   logic [3:0]  len;
   logic [0:3]  immediate_nibble, im;
   logic [0:7]  field_mask, m;
   logic [63:0] fp_src_a, x, y;
   logic [0:63] fp_src_b;
   logic [0:31] exc_set, st, r, e;
   logic [63:0] ca [6] = '{64'h0, 64'h8000_0000_0000_0000, 64'h3FF0_0000_0000_0000,
                           64'hC000_0000_0000_0000, 64'h7FF8_0000_0000_0000,
                           64'h7FF0_0000_0000_0001};
   wire         fp_busy, exc_pending, op_ready_q, done_q, fp_hold_q, fp_mem_hold_q;
   wire         fp_dest_wr_q, cr_wr_q, cr1_wr_q;
   wire [0:31]  fp_status_control_reg;
   wire [0:63]  fp_dest_q;
   wire [2:0]   cr_field_q;
   wire [0:3]   cr_data_q, cr1_data_q;
   int          miscompares = 0, checks_done = 0, cyc = 0, lat;
   fpcsu_top dut (.clk, .reset_n, .ce, .op_valid, .op_code, .op_dot, .dest_cond_field,
      .src_status_field, .immediate_nibble, .field_mask, .fp_src_a, .fp_src_b, .fp_busy,
      .exc_pending, .exc_set, .op_ready_q, .done_q, .fp_hold_q, .fp_mem_hold_q,
      .fp_status_control_reg, .fp_dest_wr_q, .fp_dest_q, .cr_wr_q, .cr_field_q, .cr_data_q,
      .cr1_wr_q, .cr1_data_q);
   fpcsu_seq_model seq (.clk, .reset_n, .go, .len, .fp_busy, .exc_pending);
   function automatic logic nan(input logic [63:0] a);
      return &a[62:52] && |a[51:0];
   endfunction
   function automatic logic [0:3] rel(input logic [63:0] a, b);
      logic [63:0] ka, kb;
      if (nan(a) || nan(b))
         return 4'b0001;
      if (a[62:0] == 63'h0 && b[62:0] == 63'h0)
         return 4'b0010;
      ka = a[63] ? ~a : {1'b1, a[62:0]};
      kb = b[63] ? ~b : {1'b1, b[62:0]};
      return ka < kb ? 4'b1000 : (ka > kb ? 4'b0100 : 4'b0010);
   endfunction
   function automatic logic [0:31] merge(input logic [0:7] mk, input logic [0:31] s, v);
      for (int k = 0; k < 32; k++)
         if (mk[k / 4])
            s[k] = v[k];
      return s;
   endfunction
   task chk(input string n, input logic [63:0] s, input logic [63:0] x_exp);
      checks_done++;
      if (s !== x_exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, x_exp, s);
      end
   endtask
   task close_out;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task run(input logic [2:0] op, f, input logic d, input logic [0:3] i,
            input logic [0:7] mk, input logic [63:0] a, input logic [0:63] b);
      @(posedge clk);
      {op_code, dest_cond_field, src_status_field, op_dot} <= {op, f, f, d};
      {immediate_nibble, field_mask, fp_src_a, fp_src_b} <= {i, mk, a, b};
      op_valid <= 1'b1;
      @(posedge clk);
      op_valid <= 1'b0;
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
      end while (done_q !== 1'b1 && lat < 40);
   endtask
   task wr(input logic [0:31] v);
      run(`FPCSU_OP_MTFSF, 3'h0, 1'b0, 4'h0, 8'hFF, 64'h0, {32'h0, v});
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         close_out;
      end
   end
   initial begin
      {reset_n, op_valid, op_dot, go, len, op_code, dest_cond_field} = '0;
      {src_status_field, immediate_nibble, field_mask, fp_src_a, fp_src_b, exc_set} = '0;
      ce = 1'b1;
      r = $urandom(32'h8b852365);
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      // corner pairs then random; cond field one not examined
      for (int i = 0; i < 100; i++) begin
         x = i < 72 ? ca[i / 12] : {$urandom, $urandom};
         y = i < 72 ? ca[(i / 2) % 6] : {$urandom, $urandom};
         ve = 1'($urandom);
         fld = 3'($urandom);
         wr({24'h0, ve, 7'h0});
         run(3'(i % 2), fld, 1'b0, 4'h0, 8'h00, x, y);
         sn = (nan(x) && !x[51]) || (nan(y) && !y[51]);
         dt = (i % 2 == 1) && (nan(x) || nan(y)) && !(sn && ve);
         chk("cmp_lat", lat, 2);
         chk("cmp_code", cr_data_q, rel(x, y));
         chk("cmp_field", {cr_wr_q, cr_field_q}, {1'b1, fld});
         chk("fp_cond", fp_status_control_reg[16:19], rel(x, y));
         chk("snan_flag", fp_status_control_reg[7], sn);
         chk("cmp_inv", fp_status_control_reg[12], dt);
      end
      $display("compare test done");
      // field writes, plain and dot forms
      for (int i = 0; i < 24; i++) begin
         st = fp_status_control_reg;
         fld = 3'($urandom % 7 + 1);
         {im, m, r, dt} = {4'($urandom), 8'($urandom) & 8'h7F, $urandom, 1'($urandom)};
         run(i % 2 ? `FPCSU_OP_MTFSF : `FPCSU_OP_MTFSFI, fld, dt, im, m, 64'h0, {32'h0, r});
         e = i % 2 ? merge(m, st, r) : merge(8'h80 >> fld, st, {8{im}});
         chk("fields", fp_status_control_reg[4:31], e[4:31]);
         chk("cr1_wr", {cr1_wr_q, cr_wr_q}, {dt, 1'b0});
         if (dt)
            chk("cr1_data", cr1_data_q, fp_status_control_reg[0:3]);
      end
      wr(32'h0);
      run(`FPCSU_OP_MTFSFI, 3'h0, 1'b0, 4'b0111, 8'h00, 64'h0, 64'h0);
      chk("imm_f0", fp_status_control_reg[0:3], 4'b0001);
      wr(32'h0);
      run(`FPCSU_OP_MTFSF, 3'h0, 1'b0, 4'h0, 8'h80, 64'h0, {32'h0, 32'h7000_0000});
      chk("mask_f0", fp_status_control_reg[0:3], 4'b0001);
      $display("field write test done");
      // copy to condition field clears exceptions only
      wr(32'h0F00_00A0);
      for (int k = 1; k < 7; k += 5) begin
         run(`FPCSU_OP_MCRFS, 3'(k), 1'b0, 4'h0, 8'h00, 64'h0, 64'h0);
         chk("mcrfs_data", {cr_field_q, cr_data_q}, {3'(k), k == 1 ? 4'hF : 4'hA});
         chk("mcrfs_clr", fp_status_control_reg[4 * k +: 4], k == 1 ? 4'h0 : 4'hA);
      end
      wr(32'h0000_50F0);
      chk("mask_all", fp_status_control_reg, 32'h0000_50F0);
      run(`FPCSU_OP_MFS, 3'h0, 1'b1, 4'h0, 8'h00, 64'h0, 64'h0);
      chk("mfs_data", fp_dest_q, {32'h0, 32'h0000_50F0});
      chk("mfs_wr", {fp_dest_wr_q, cr1_wr_q}, 2'b11);
      $display("move test done");
      // status op waits out busy and pending work
      for (int k = 0; k < 10; k += 3) begin
         @(posedge clk);
         {go, len} <= {1'b1, 4'(k)};
         @(posedge clk);
         go <= 1'b0;
         run(`FPCSU_OP_MFS, 3'h0, 1'b0, 4'h0, 8'h00, 64'h0, 64'h0);
         chk("sync_lat", lat, k > 2 ? k + 1 : 3);
         chk("mem_hold", fp_mem_hold_q, 1'b0);
      end
      $display("sync test done");
      wr(32'h0);
      @(posedge clk);
      exc_set <= 32'h0800_0000;
      @(posedge clk);
      exc_set <= 32'h0;
      @(negedge clk);
      chk("exc_sum", {fp_status_control_reg[0], fp_status_control_reg[4]}, 2'b11);
      // Clock enable low freezes the status register against raised exceptions
      st = fp_status_control_reg;
      @(posedge clk);
      {ce, exc_set} <= {1'b0, 32'h0000_0400};
      repeat (2) @(posedge clk);
      {ce, exc_set} <= {1'b1, 32'h0000_0000};
      @(negedge clk);
      chk("ce_freeze", fp_status_control_reg, st);
      $display("exception test done");
      close_out;
   end
endmodule
